/* File: hw/avb_endpoint_config_slave.sv */
// Configuration slave: bus handshake, timing-frame buffers and control registers.
// Assumes a single bus master issuing single transfers, and same-clock partner logic.
`timescale 1ns/10ps
`include "avb_cfg_map.svh"
module avb_endpoint_config_slave #(
  parameter logic [31:0] WINDOW_BASE = 32'h0000_0000
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        plb_pavalid_i,
  input  wire logic        plb_rnw_i,
  input  wire logic [31:0] plb_abus_i,
  input  wire logic [3:0]  plb_be_i,
  input  wire logic [31:0] plb_wrdbus_i,
  output logic             sl_wait_o,
  output logic             sl_addrack_o,
  output logic             sl_rddack_o,
  output logic             sl_wrdack_o,
  output logic      [31:0] sl_rddbus_o,
  output logic             tx_req_o,
  output logic      [2:0]  tx_slot_o,
  input  wire logic        tx_grant_i,
  input  wire logic        tx_done_i,
  output logic             tx_sent_irq_o,
  input  wire logic [8:0]  tx_buf_addr_i,
  input  wire logic [3:0]  tx_buf_we_i,
  input  wire logic [31:0] tx_buf_wdata_i,
  output logic      [31:0] tx_buf_rdata_o,
  input  wire logic        rx_done_i,
  input  wire logic [3:0]  rx_slot_i,
  output logic             rx_recv_irq_o,
  output logic             rx_flush_o,
  input  wire logic [9:0]  rx_buf_addr_i,
  input  wire logic [3:0]  rx_buf_we_i,
  input  wire logic [31:0] rx_buf_wdata_i,
  input  wire logic        rx_tagged_i,
  input  wire logic [2:0]  rx_vlan_prio_i,
  input  wire logic        rx_hdr_match_i,
  output logic             rx_to_av_o,
  output logic             rx_legacy_pass_o,
  output logic      [2:0]  prio_a_o,
  output logic      [2:0]  prio_b_o,
  output logic             promisc_o,
  output logic      [19:0] send_slope_o,
  output logic      [19:0] idle_slope_o,
  output logic      [29:0] ns_offset_o,
  output logic             rtc_load_o
);
  avb_cfg_pkg::bus_state_e state_q, state_d;
  avb_cfg_pkg::bus_req_s   req_q;
  logic [7:0]  pending_q;
  logic [2:0]  inflight_q;
  logic        busy_q;
  logic [2:0]  last_tx_q;
  logic [3:0]  last_rx_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = (old & ~m) | (nw & m);
  endfunction

  function automatic logic [3:0] lowest(input logic [7:0] v);
    lowest = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        lowest = {1'b1, i[2:0]};
      end
    end
  endfunction

  // Window check of the live bus address; offset decode of the captured request
  wire logic        in_win   = plb_abus_i[31:`WIN_BITS] == WINDOW_BASE[31:`WIN_BITS];
  wire logic [13:0] off      = req_q.off;
  wire logic        hit_rx   = off <= `OFF_RX_LAST;
  wire logic        hit_tx   = off >= `OFF_TX_BASE && off <= `OFF_TX_LAST;
  wire logic        hit_txc  = {off[13:2], 2'b00} == `OFF_TX_CTRL;
  wire logic        hit_rxc  = {off[13:2], 2'b00} == `OFF_RX_CTRL;
  wire logic        hit_flt  = {off[13:2], 2'b00} == `OFF_FILTER;
  wire logic        hit_snd  = {off[13:2], 2'b00} == `OFF_SEND_SLOPE;
  wire logic        hit_idl  = {off[13:2], 2'b00} == `OFF_IDLE_SLOPE;
  wire logic        hit_ns   = {off[13:2], 2'b00} == `OFF_NS_OFFSET;
  wire logic        access   = state_q == avb_cfg_pkg::ST_ADDR;
  wire logic        wr_now   = access && !req_q.rnw;
  wire logic [31:0] wd       = req_q.wdata;
  wire logic [3:0]  be       = req_q.be;

  // Register write strobes and side effects
  wire logic        acc_txc  = access && hit_txc;                       // RULE11
  wire logic        acc_rxc  = access && hit_rxc;                       // RULE14
  wire logic [7:0]  send_set = (wr_now && hit_txc && be[0]) ? wd[7:0] : 8'h00; // RULE8
  wire logic        flush    = wr_now && hit_rxc && be[0] && wd[`RXC_FLUSH_BIT]; // RULE12
  wire logic [3:0]  rx_wr_be = 4'h0;                                     // RULE21
  wire logic [3:0]  tx_wr_be = (wr_now && hit_tx) ? be : 4'h0;          // RULE7

  // Arbitration toward the transmit arbiter
  wire logic [7:0]  inflight_m = busy_q ? (8'h01 << inflight_q) : 8'h00;
  wire logic [3:0]  pick       = lowest(pending_q & ~inflight_m);      // RULE22
  wire logic [7:0]  done_m     = (tx_done_i && busy_q) ? inflight_m : 8'h00;
  wire logic [7:0]  pending_d  = (pending_q & ~done_m) | send_set;      // RULE9

  // Buffers
  logic [31:0] rx_rdata, tx_rdata;

  avb_dp_ram #(.AW(10)) u_rx_buf (
    .core_clk_i (core_clk_i),
    .a_we_i     (rx_wr_be),
    .a_addr_i   (off[11:2]),
    .a_wdata_i  (wd),
    .a_rdata_o  (rx_rdata),
    .b_we_i     (rx_buf_we_i),
    .b_addr_i   (rx_buf_addr_i),
    .b_wdata_i  (rx_buf_wdata_i),
    .b_rdata_o  ()
  );

  avb_dp_ram #(.AW(9)) u_tx_buf (
    .core_clk_i (core_clk_i),
    .a_we_i     (tx_wr_be),
    .a_addr_i   (off[10:2]),
    .a_wdata_i  (wd),
    .a_rdata_o  (tx_rdata),
    .b_we_i     (tx_buf_we_i),
    .b_addr_i   (tx_buf_addr_i),
    .b_wdata_i  (tx_buf_wdata_i),
    .b_rdata_o  (tx_buf_rdata_o)
  );

  // Read data selection; unused bits and unmapped offsets read zero
  wire logic [31:0] txc_word = {13'h0000, last_tx_q, pending_q, 8'h00}; // RULE8 RULE10 RULE23
  wire logic [31:0] rxc_word = {20'h00000, last_rx_q, 8'h00};         // RULE13 RULE12 RULE23
  wire logic [31:0] flt_word = {15'h0000, promisc_o, 5'h00, prio_b_o, 5'h00, prio_a_o}; // RULE23
  wire logic [31:0] rd_word  =
    hit_rx  ? rx_rdata :                                                 // RULE6
    hit_tx  ? tx_rdata :                                                 // RULE7
    hit_txc ? txc_word :
    hit_rxc ? rxc_word :
    hit_flt ? flt_word :
    hit_snd ? {12'h000, send_slope_o} :                                  // RULE17
    hit_idl ? {12'h000, idle_slope_o} :                                  // RULE18
    hit_ns  ? {2'h0, ns_offset_o} : 32'h0000_0000;

  wire logic [31:0] flt_new = merge(flt_word, wd, be);
  wire logic [31:0] snd_new = merge({12'h000, send_slope_o}, wd, be);
  wire logic [31:0] idl_new = merge({12'h000, idle_slope_o}, wd, be);
  wire logic [31:0] ns_new  = merge({2'h0, ns_offset_o}, wd, be);

  // Bus handshake sequence; fixed latency keeps one transfer at a time
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      avb_cfg_pkg::ST_IDLE:  if (plb_pavalid_i && in_win) state_d = avb_cfg_pkg::ST_WAIT;
      avb_cfg_pkg::ST_WAIT:  state_d = avb_cfg_pkg::ST_ADDR;
      avb_cfg_pkg::ST_ADDR:  state_d = avb_cfg_pkg::ST_FETCH;
      avb_cfg_pkg::ST_FETCH: state_d = avb_cfg_pkg::ST_DATA;
      avb_cfg_pkg::ST_DATA:  state_d = avb_cfg_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q      <= avb_cfg_pkg::ST_IDLE;
      req_q        <= '0;
      sl_wait_o    <= 1'b0;
      sl_addrack_o <= 1'b0;
      sl_rddack_o  <= 1'b0;
      sl_wrdack_o  <= 1'b0;
      sl_rddbus_o  <= 32'h0000_0000;
    end else begin
      state_q      <= state_d;
      sl_wait_o    <= state_d == avb_cfg_pkg::ST_WAIT;                          // RULE2
      sl_addrack_o <= state_d == avb_cfg_pkg::ST_ADDR;                          // RULE2
      sl_rddack_o  <= state_d == avb_cfg_pkg::ST_DATA && req_q.rnw;             // RULE3
      sl_wrdack_o  <= state_d == avb_cfg_pkg::ST_DATA && !req_q.rnw;            // RULE4
      sl_rddbus_o  <= (state_d == avb_cfg_pkg::ST_DATA && req_q.rnw) ? rd_word : 32'h0000_0000;
      if (state_q == avb_cfg_pkg::ST_IDLE && state_d == avb_cfg_pkg::ST_WAIT) begin
        req_q <= '{off: plb_abus_i[13:0] - WINDOW_BASE[13:0], rnw: plb_rnw_i,
                   be: plb_be_i, wdata: plb_wrdbus_i};                           // RULE5 RULE1
      end
    end
  end

  // Transmit request tracking
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pending_q     <= 8'h00;
      busy_q        <= 1'b0;
      inflight_q    <= 3'h0;
      last_tx_q     <= 3'h0;
      tx_req_o      <= 1'b0;
      tx_slot_o     <= 3'h0;
      tx_sent_irq_o <= 1'b0;
    end else begin
      pending_q     <= pending_d;
      tx_req_o      <= pick[3] && !busy_q && !tx_grant_i;
      tx_slot_o     <= pick[2:0];
      tx_sent_irq_o <= (tx_sent_irq_o && !acc_txc) || (tx_done_i && busy_q);   // RULE11
      if (tx_grant_i && tx_req_o) begin
        busy_q     <= 1'b1;
        inflight_q <= tx_slot_o;
      end else if (tx_done_i && busy_q) begin
        busy_q    <= 1'b0;
        last_tx_q <= inflight_q;                                                // RULE10
      end
    end
  end

  // Receive status and steering
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_rx_q        <= 4'h0;
      rx_recv_irq_o    <= 1'b0;
      rx_flush_o       <= 1'b0;
      rx_to_av_o       <= 1'b0;
      rx_legacy_pass_o <= 1'b0;
    end else begin
      rx_recv_irq_o    <= (rx_recv_irq_o && !acc_rxc) || rx_done_i;             // RULE14
      rx_flush_o       <= flush;                                                // RULE12
      rx_to_av_o       <= rx_tagged_i &&
                          (rx_vlan_prio_i == prio_a_o || rx_vlan_prio_i == prio_b_o); // RULE15
      rx_legacy_pass_o <= promisc_o || rx_hdr_match_i;                          // RULE16
      if (rx_done_i) begin
        last_rx_q <= rx_slot_i;                                                 // RULE13
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prio_a_o     <= `RST_PRIA;
      prio_b_o     <= `RST_PRIB;
      promisc_o    <= `RST_PROM;
      send_slope_o <= `RST_SEND_SLOPE;
      idle_slope_o <= `RST_IDLE_SLOPE;
      ns_offset_o  <= `RST_NS_OFFSET;
      rtc_load_o   <= 1'b0;
    end else begin
      rtc_load_o <= wr_now && hit_ns;                                           // RULE20
      if (wr_now && hit_flt) begin
        prio_a_o  <= flt_new[`FLT_PRIA_LSB +: 3];                               // RULE15
        prio_b_o  <= flt_new[`FLT_PRIB_LSB +: 3];
        promisc_o <= flt_new[`FLT_PROM_BIT];                                    // RULE16
      end
      if (wr_now && hit_snd) begin
        send_slope_o <= snd_new[19:0];                                          // RULE17 RULE19
      end
      if (wr_now && hit_idl) begin
        idle_slope_o <= idl_new[19:0];                                          // RULE18 RULE19
      end
      if (wr_now && hit_ns) begin
        ns_offset_o <= ns_new[29:0];                                            // RULE20
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  wait_then_ack_a: assert property ($rose(sl_wait_o) |=> sl_addrack_o && !sl_wait_o) // RULE2
    else $error("address ack does not follow wait");
  read_ack_a: assert property (sl_addrack_o && req_q.rnw |-> ##2 sl_rddack_o) // RULE3
    else $error("read ack not two cycles after address ack");
  write_ack_a: assert property (sl_addrack_o && !req_q.rnw |-> ##2 sl_wrdack_o) // RULE4
    else $error("write ack not two cycles after address ack");
  single_ack_a: assert property ((sl_rddack_o || sl_wrdack_o) |=> !sl_rddack_o && !sl_wrdack_o
                                 && !sl_addrack_o) // RULE1
    else $error("data ack longer than one cycle");
  send_reads_zero_a: assert property (sl_rddack_o && hit_txc |-> sl_rddbus_o[7:0] == 8'h00) // RULE8
    else $error("send bits read nonzero");
  pend_set_a: assert property (send_set[0] |=> pending_q[0]) // RULE9
    else $error("request did not mark region pending");
  tx_irq_clr_a: assert property (acc_txc && !tx_done_i |=> !tx_sent_irq_o) // RULE11
    else $error("frame-sent interrupt not cleared by access");
  rx_irq_clr_a: assert property (acc_rxc && !rx_done_i |=> !rx_recv_irq_o) // RULE14
    else $error("frame-received interrupt not cleared by access");
  flush_pulse_a: assert property (flush |=> rx_flush_o ##1 !rx_flush_o) // RULE12
    else $error("flush not a single pulse");
  steer_av_a: assert property (rx_tagged_i && rx_vlan_prio_i == prio_b_o |=> rx_to_av_o) // RULE15
    else $error("matching tagged frame not steered to AV");
  lowest_first_a: assert property (tx_req_o |-> pending_q[tx_slot_o] ||
                                   $past(pending_q[tx_slot_o])) // RULE22
    else $error("request names a slot that is not pending");
  lowest_pick_a: assert property (tx_req_o |-> ($past(pending_q) &
                                  ((8'h01 << tx_slot_o) - 8'h01)) == 8'h00) // RULE22
    else $error("request skips a lower pending slot");

  read_cov_c: cover property (sl_rddack_o && hit_tx);
  write_cov_c: cover property (sl_wrdack_o && hit_txc);
  sent_cov_c: cover property (tx_done_i && busy_q && pending_q[7]);
  load_cov_c: cover property (rtc_load_o);
  flush_cov_c: cover property (rx_flush_o);
endmodule

/* File: hw/avb_cfg_map.svh */
// Offsets, field positions and reset values of the endpoint configuration slave.
// Assumes byte offsets relative to the window base; no other state is kept here.
// Summary of operation
// RULE1: Simple 32-bit slave, single transfers only.
// RULE2: Address phase stretched by wait, then addrAck.
// RULE3: Read data returned with delayed read acknowledge.
// RULE4: Write data sampled with delayed write acknowledge.
// RULE5: Each window address selects one byte; the code ignores address bits 1-0 and selects a 32-bit word with byte enables.
// RULE6: Receive buffer 0x0000-0x0FFF readable over bus.
// RULE7: Transmit buffer 0x1000-0x17FF read and write.
// RULE8: Send bits request region transmit, read zero.
// RULE9: Waiting bits set on request, cleared when sent.
// RULE10: Last sent slot index in bits 18-16.
// RULE11: Transmit control access clears frame-sent interrupt.
// RULE12: Flush bit empties receive buffer, reads zero.
// RULE13: Last received slot index in bits 11-8.
// RULE14: Receive control access clears frame-received interrupt.
// RULE15: Tagged frame matching either priority goes AV.
// RULE16: Promiscuous bit passes all legacy frames.
// RULE17: Send slope 20 bits, reset 2048.
// RULE18: Idle slope 20 bits, reset 6144.
// RULE19: Arbiter caps AV bandwidth using both slopes.
// RULE20: Nanosecond offset write loads clock offsets together.
// RULE21: Writes to receive buffer are ignored.
// RULE22: Lowest numbered requested region served first.
// RULE23: Unused register bits read zero, ignore writes.
`ifndef AVB_CFG_MAP_SVH
`define AVB_CFG_MAP_SVH
`define WIN_BITS       14
`define OFF_RX_LAST    14'h0FFF
`define OFF_TX_BASE    14'h1000
`define OFF_TX_LAST    14'h17FF
`define OFF_TX_CTRL    14'h2000
`define OFF_RX_CTRL    14'h2004
`define OFF_FILTER     14'h2008
`define OFF_SEND_SLOPE 14'h200C
`define OFF_IDLE_SLOPE 14'h2010
`define OFF_NS_OFFSET  14'h2800
`define TXC_WAIT_LSB   8
`define TXC_LAST_LSB   16
`define RXC_FLUSH_BIT  0
`define RXC_LAST_LSB   8
`define FLT_PRIA_LSB   0
`define FLT_PRIB_LSB   8
`define FLT_PROM_BIT   16
`define RST_PRIA       3'h3
`define RST_PRIB       3'h2
`define RST_PROM       1'h1
`define RST_SEND_SLOPE 20'h00800
`define RST_IDLE_SLOPE 20'h01800
`define RST_NS_OFFSET  30'h00000000
`endif

/* File: hw/avb_cfg_pkg.sv */
// Types used by the configuration slave's bus handshake.
// Assumes avb_cfg_map.svh supplies the numeric layout.
package avb_cfg_pkg;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_WAIT  = 5'h02,
    ST_ADDR  = 5'h04,
    ST_FETCH = 5'h08,
    ST_DATA  = 5'h10
  } bus_state_e;

  typedef struct packed {
    logic [13:0] off;
    logic        rnw;
    logic [3:0]  be;
    logic [31:0] wdata;
  } bus_req_s;
endpackage

/* File: hw/avb_dp_ram.sv */
// Dual-port byte-writable buffer memory with registered read data.
// Assumes both ports run on the one core clock; port B wins a same-byte clash.
`timescale 1ns/10ps
module avb_dp_ram #(
  parameter int AW = 10
) (
  input  wire logic          core_clk_i,
  input  wire logic [3:0]    a_we_i,
  input  wire logic [AW-1:0] a_addr_i,
  input  wire logic [31:0]   a_wdata_i,
  output logic      [31:0]   a_rdata_o,
  input  wire logic [3:0]    b_we_i,
  input  wire logic [AW-1:0] b_addr_i,
  input  wire logic [31:0]   b_wdata_i,
  output logic      [31:0]   b_rdata_o
);
  logic [31:0] mem [0:(1<<AW)-1];

  // One process for both ports keeps a single driver on the array
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (a_we_i[i]) begin
        mem[a_addr_i][8*i +: 8] <= a_wdata_i[8*i +: 8];
      end
      if (b_we_i[i]) begin
        mem[b_addr_i][8*i +: 8] <= b_wdata_i[8*i +: 8];
      end
    end
    a_rdata_o <= mem[a_addr_i];
    b_rdata_o <= mem[b_addr_i];
  end
endmodule

/* File: verif/tx_arb_model.sv */
// Transmit arbiter stand-in: takes the requested slot, later reports it sent.
// Assumes the core clock; lat_i sets both the grant delay and the send time.
`timescale 1ns/10ps
module tx_arb_model (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       req_i,
  input  wire logic [2:0] slot_i,
  input  wire logic [3:0] lat_i,
  output logic            grant_o,
  output logic            done_o,
  output logic      [8:0] addr_o
);
  logic       busy_q;
  logic [3:0] cnt_q;
  wire        fire = (cnt_q == lat_i);
  wire        take = !busy_q && req_i && !grant_o;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q  <= 1'b0;
      cnt_q   <= 4'h0;
      grant_o <= 1'b0;
      done_o  <= 1'b0;
      addr_o  <= 9'h000;
    end else begin
      grant_o <= take && fire;
      done_o  <= busy_q && fire;
      // Request may still show in the grant cycle, so it is not taken twice
      if (busy_q || take) cnt_q <= fire ? 4'h0 : cnt_q + 4'h1;
      if (take && fire) begin
        busy_q <= 1'b1;
        addr_o <= {slot_i, 6'h00};
      end
      if (busy_q && fire) busy_q <= 1'b0;
    end
  end
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the endpoint configuration slave.
// Assumes tx_arb_model as transmit arbiter; the bench plays bus master and splitter.
`timescale 1ns/10ps
module testbench;
  `define CHK(g, e) cmp(32'(g), 32'(e))
  logic        core_clk_i, rst_n_i, plb_pavalid_i, plb_rnw_i, sl_wait_o, sl_addrack_o;
  logic        sl_rddack_o, sl_wrdack_o, tx_req_o, tx_grant_i, tx_done_i, tx_sent_irq_o;
  logic        rx_done_i, rx_recv_irq_o, rx_flush_o, rx_tagged_i, rx_hdr_match_i;
  logic        rx_to_av_o, rx_legacy_pass_o, promisc_o, rtc_load_o;
  logic [31:0] plb_abus_i, plb_wrdbus_i, sl_rddbus_o, tx_buf_wdata_i, tx_buf_rdata_o;
  logic [31:0] rx_buf_wdata_i, v, w;
  logic [3:0]  plb_be_i, tx_buf_we_i, rx_slot_i, rx_buf_we_i, lat;
  logic [2:0]  tx_slot_o, rx_vlan_prio_i, prio_a_o, prio_b_o;
  logic [8:0]  tx_buf_addr_i;
  logic [9:0]  rx_buf_addr_i;
  logic [19:0] send_slope_o, idle_slope_o;
  logic [29:0] ns_offset_o;
  logic [31:0] q[$];
  logic [31:0] gq[$];
  logic [31:0] ra[4] = '{32'h2008, 32'h200C, 32'h2010, 32'h2800};
  logic [31:0] rm[4] = '{32'h00010707, 32'h000FFFFF, 32'h000FFFFF, 32'h3FFFFFFF};
  int          err_count, tests_run, loads, flushes, acks, n;

  avb_endpoint_config_slave DUT (.core_clk_i, .rst_n_i, .plb_pavalid_i, .plb_rnw_i,
    .plb_abus_i, .plb_be_i, .plb_wrdbus_i, .sl_wait_o, .sl_addrack_o, .sl_rddack_o,
    .sl_wrdack_o, .sl_rddbus_o, .tx_req_o, .tx_slot_o, .tx_grant_i, .tx_done_i,
    .tx_sent_irq_o, .tx_buf_addr_i, .tx_buf_we_i, .tx_buf_wdata_i, .tx_buf_rdata_o,
    .rx_done_i, .rx_slot_i, .rx_recv_irq_o, .rx_flush_o, .rx_buf_addr_i, .rx_buf_we_i,
    .rx_buf_wdata_i, .rx_tagged_i, .rx_vlan_prio_i, .rx_hdr_match_i, .rx_to_av_o,
    .rx_legacy_pass_o, .prio_a_o, .prio_b_o, .promisc_o, .send_slope_o, .idle_slope_o,
    .ns_offset_o, .rtc_load_o);
  tx_arb_model arb (.core_clk_i, .rst_n_i, .req_i(tx_req_o), .slot_i(tx_slot_o),
    .lat_i(lat), .grant_o(tx_grant_i), .done_o(tx_done_i), .addr_o(tx_buf_addr_i));

  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic stop_if(input logic hit);
    if (hit) begin
      err_count++;
      give_verdict();
    end
  endtask

  // Request held one cycle past the sampled addrack, then the data ack is awaited
  task automatic bus(input logic r, input logic [31:0] a, input logic [3:0] b,
                     input logic [31:0] d);
    int k;
    @(negedge core_clk_i);
    {plb_pavalid_i, plb_rnw_i, plb_abus_i, plb_be_i, plb_wrdbus_i} = {1'b1, r, a, b, d};
    k = 0;
    do begin @(negedge core_clk_i); k++; end while (sl_addrack_o !== 1'b1 && k < 20);
    stop_if(k >= 20);
    @(negedge core_clk_i);
    plb_pavalid_i = 1'b0;
    k = 0;
    while (!(sl_rddack_o === 1'b1 || sl_wrdack_o === 1'b1) && k < 20) begin
      @(negedge core_clk_i);
      k++;
    end
    stop_if(k >= 20);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b1, a, 4'hF, 32'h0);
  endtask

  task automatic wait_grants(input int cnt);
    n = 0;
    while (gq.size() < cnt && n < 400) begin @(negedge core_clk_i); n++; end
    stop_if(n >= 400);
    repeat (40) @(negedge core_clk_i);
  endtask

  always @(negedge core_clk_i) begin
    if (sl_rddack_o === 1'b1) begin
      stop_if(q.size() == 0);
      `CHK(sl_rddbus_o, q.pop_front());
    end
    if (tx_grant_i === 1'b1 && tx_req_o === 1'b1) gq.push_back(32'(tx_slot_o));
    if (rtc_load_o === 1'b1) loads++;
    if (rx_flush_o === 1'b1) flushes++;
    if (sl_addrack_o === 1'b1) acks++;
  end

  initial begin
    {plb_pavalid_i, plb_rnw_i, plb_abus_i, plb_be_i, plb_wrdbus_i} = '0;
    {tx_buf_we_i, tx_buf_wdata_i, rx_done_i, rx_slot_i, rx_buf_addr_i} = '0;
    {rx_buf_we_i, rx_buf_wdata_i, rx_tagged_i, rx_vlan_prio_i, rx_hdr_match_i} = '0;
    {err_count, tests_run, loads, flushes, acks} = '0;
    lat = 4'hF;
    rst_n_i = 1'b0;
    v = $urandom(32'h81587fab);
    repeat (10) @(posedge core_clk_i);
    @(negedge core_clk_i);
    rst_n_i = 1'b1;
    rd(32'h2000, 32'h0);
    rd(32'h2004, 32'h0);
    rd(32'h2008, 32'h00010203);
    rd(32'h200C, 32'h800);
    rd(32'h2010, 32'h1800);
    rd(32'h2800, 32'h0);
    rd(32'h2014, 32'h0);
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      bus(1'b0, ra[i], 4'hF, v);
      rd(ra[i], v & rm[i]);
      if (i == 2) w = v;
    end
    `CHK(ns_offset_o, v[29:0]);
    `CHK(loads, 1);
    `CHK(idle_slope_o, w[19:0]);
    bus(1'b0, 32'h2008, 4'hF, 32'h00000302);
    for (int j = 0; j < 2; j++) begin
      if (j == 1) bus(1'b0, 32'h2008, 4'hF, 32'h00010302);
      for (int i = 0; i < 16; i++) begin
        @(negedge core_clk_i);
        {rx_tagged_i, rx_vlan_prio_i} = 4'(i);
        rx_hdr_match_i = i[0];
        @(negedge core_clk_i);
        `CHK(rx_to_av_o, i[3] && (i[2:0] == 2 || i[2:0] == 3));
        `CHK(rx_legacy_pass_o, j[0] | i[0]);
      end
    end
    $display("filter and slopes done");
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      w = $urandom;
      n = (i == 0) ? 32'h1000 : (i == 1) ? 32'h17FC : 32'h1000 + ($urandom & 32'h7FC);
      bus(1'b0, n, 4'hF, v);
      bus(1'b0, n, 4'h5, w);
      rd(n, (v & 32'hFF00FF00) | (w & 32'h00FF00FF));
    end
    @(negedge core_clk_i);
    {rx_buf_addr_i, rx_buf_we_i, rx_buf_wdata_i} = {10'h3FF, 4'hF, v};
    @(negedge core_clk_i);
    rx_buf_we_i = 4'h0;
    bus(1'b0, 32'h0FFC, 4'hF, ~v);
    rd(32'h0FFD, v);
    $display("buffers done");
    bus(1'b0, 32'h1500, 4'hF, v);
    bus(1'b0, 32'h2000, 4'hF, 32'h28);
    rd(32'h2000, 32'h2800);
    wait_grants(2);
    `CHK(tx_buf_rdata_o, v);
    `CHK(gq[0], 3);
    `CHK(gq[1], 5);
    `CHK(tx_sent_irq_o, 1);
    rd(32'h2000, 32'h00050000);
    `CHK(tx_sent_irq_o, 0);
    lat = 4'h0;
    bus(1'b0, 32'h2000, 4'hF, 32'hFF);
    wait_grants(10);
    for (int i = 0; i < 8; i++) `CHK(gq[i + 2], i);
    rd(32'h2000, 32'h00070000);
    $display("transmit requests done");
    @(negedge core_clk_i);
    {rx_done_i, rx_slot_i} = {1'b1, 4'($urandom)};
    @(negedge core_clk_i);
    rx_done_i = 1'b0;
    `CHK(rx_recv_irq_o, 1);
    rd(32'h2004, {rx_slot_i, 8'h00});
    `CHK(rx_recv_irq_o, 0);
    bus(1'b0, 32'h2004, 4'hF, 32'h1);
    `CHK(flushes, 1);
    rd(32'h2004, {rx_slot_i, 8'h00});
    n = acks;
    @(negedge core_clk_i);
    {plb_pavalid_i, plb_rnw_i, plb_abus_i} = {2'b11, 32'h4000};
    repeat (8) @(negedge core_clk_i);
    plb_pavalid_i = 1'b0;
    `CHK(acks, n);
    $display("receive and window done");
    give_verdict();
  end
endmodule
